/* File: verilog/thc_map.svh */
`ifndef THC_MAP_SVH
`define THC_MAP_SVH
// timing
`define THC_CLK_HZ 50000000
`define THC_CYCLE_US 1000
`define THC_CYCLE_CLKS ((`THC_CLK_HZ / 1000000) * `THC_CYCLE_US)
`define THC_STEP_MS 10
`define THC_SYNC_MAX_STEPS 6'h32
`define THC_INTER_MS 500
`define THC_STEP_TICKS ((`THC_STEP_MS * 1000) / `THC_CYCLE_US)
`define THC_INTER_TICKS ((`THC_INTER_MS * 1000) / `THC_CYCLE_US)
// register offsets
`define THC_OFS_CTRL 8'h00
`define THC_OFS_SYNC1 8'h04
`define THC_OFS_SYNC2 8'h08
`define THC_OFS_STATUS 8'h0c
// control fields
`define THC_CTRL_RUN 0
`define THC_CTRL_FALL 1
`define THC_CTRL_THREE 2
`define THC_CTRL_NEN 3
// reset values
`define THC_CTRL_RST 5'h00
`define THC_WIN_RST 6'h00
`endif

/* File: verilog/thc_pkg.sv */
package thc_pkg;
`include "thc_map.svh"

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_REL = 4'b0100,
		ST_LOCK = 4'b1000
	} sync_state_t;

	typedef struct packed {
		logic [9:0] s1;
		logic [9:0] s2;
		logic run;
		logic fall;
		logic three;
		logic [1:0] n_en;
		logic [5:0] win1;
		logic [5:0] win2;
		logic [15:0] div;
		logic tick;
		logic cyc_prev;
		logic run_prev;
		sync_state_t st;
		logic [9:0] wcnt;
		logic pair_rel;
		logic [2:0] seen;
		logic comb_rel;
		logic [31:0] rdata;
		logic err;
	} top_state_t;

	function automatic logic [9:0] steps_to_ticks(input logic [5:0] steps);
		return 10'(steps * `THC_STEP_TICKS);
	endfunction : steps_to_ticks
endpackage : thc_pkg

/* File: verilog/pair_eval.sv */
`timescale 1ns/1ps
module pair_eval (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// control
	input wire logic tick_i,
	input wire logic clear_i,
	input wire logic [5:0] win_i,
	// synchronised pair inputs
	input wire logic a_i,
	input wire logic b_i,
	// evaluation
	output logic active_o,
	output logic rest_o,
	output logic fault_o
);
	typedef struct packed {
		logic act;
		logic rest;
		logic fault;
		logic [9:0] tmr;
	} pair_state_t;

	pair_state_t q;
	pair_state_t d;
	logic act_now;
	logic rest_now;

	// complementary channels: a high with b low is actuated
	assign act_now = a_i && !b_i;
	assign rest_now = !a_i && b_i;

	always_comb begin
		d = q;
		if (clear_i) begin
			d = '0;
		end else if (tick_i) begin
			d.rest = rest_now;
			if (rest_now) begin
				d.fault = 1'b0;
				d.act = 1'b0;
				d.tmr = 10'h000;
			end else if (act_now) begin
				// a fault holds the pair off until it has seen rest again
				d.act = !q.fault;
				d.tmr = 10'h000;
			end else begin
				d.act = 1'b0;
				if (win_i != 6'h00 && !q.fault) begin
					if (q.tmr >= thc_pkg::steps_to_ticks(win_i) - 10'h001) begin
						d.fault = 1'b1;
					end else begin
						d.tmr = q.tmr + 10'h001;
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign active_o = q.act;
	assign rest_o = q.rest;
	assign fault_o = q.fault;
endmodule : pair_eval

/* File: verilog/two_hand_control_monitor.sv */
// Summary of operation
// - per-pair synchronous time, off or 10-500 ms
// - window between pairs fixed at 500 ms
// - outputs: release, pair one fault, pair two fault
// - pair one checked as complementary channels
// - pair two complementary, own synchronous time
// - second pair later than 500 ms: no release
// - idle only when both pairs at rest
// - missed window raises no fault, release low
// - combiner takes two or three operators
// - combiner takes zero, one or two enables
// - cycle-request edge forces release of all hands
// - release only while every used enable stays high
// - each used hand input seen low since restart/edge
// - then release when all used hands high together
// - any used enable low drives release low
// - any used hand input low drives release low
// - cycle-request edge forces release low at once
// - stop-to-run acts like a cycle-request edge
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "thc_map.svh"
module two_hand_control_monitor #(
	parameter int CYCLE_CLKS = `THC_CYCLE_CLKS
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// paired two-hand pins
	input wire logic p1_a_i,
	input wire logic p1_b_i,
	input wire logic p2_a_i,
	input wire logic p2_b_i,
	// multi-operator pins
	input wire logic [2:0] two_hand_i,
	input wire logic [1:0] enable_i,
	input wire logic cycle_req_i,
	// results
	output logic pair_release_o,
	output logic pair_one_fault_o,
	output logic pair_two_fault_o,
	output logic multi_release_o
);
	localparam logic [9:0] INTER_TICKS = 10'(`THC_INTER_TICKS);

	thc_pkg::top_state_t q;
	thc_pkg::top_state_t d;
	logic p1_act;
	logic p1_rest;
	logic p2_act;
	logic p2_rest;
	logic [2:0] th_m;
	logic [1:0] en_m;
	logic th_ok;
	logic en_ok;
	logic cyc_edge;
	logic restart;
	logic addr_ok;
	logic [31:0] rd_val;

	////////////////////////////////////////////////////////////////////////////
	// pair evaluators

	pair_eval u_pair_one (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.tick_i(q.tick),
		.clear_i(!q.run),
		.win_i(q.win1),
		.a_i(q.s2[0]),
		.b_i(q.s2[1]),
		.active_o(p1_act),
		.rest_o(p1_rest),
		.fault_o(pair_one_fault_o)
	);

	pair_eval u_pair_two (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.tick_i(q.tick),
		.clear_i(!q.run),
		.win_i(q.win2),
		.a_i(q.s2[2]),
		.b_i(q.s2[3]),
		.active_o(p2_act),
		.rest_o(p2_rest),
		.fault_o(pair_two_fault_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// combiner terms

	assign th_m = q.three ? 3'h7 : 3'h3;
	assign en_m = (q.n_en == 2'h0) ? 2'h0 : ((q.n_en == 2'h1) ? 2'h1 : 2'h3);
	assign th_ok = (q.s2[6:4] & th_m) == th_m;
	assign en_ok = (q.s2[8:7] & en_m) == en_m;
	// the request line is automation only, so a plain edge compare suffices
	assign cyc_edge = q.fall ? (q.cyc_prev && !q.s2[9]) : (!q.cyc_prev && q.s2[9]);
	assign restart = q.run && !q.run_prev;

	////////////////////////////////////////////////////////////////////////////
	// register read mux

	always_comb begin
		addr_ok = 1'b1;
		case (paddr_i)
			`THC_OFS_CTRL: rd_val = {27'h0, q.n_en, q.three, q.fall, q.run};
			`THC_OFS_SYNC1: rd_val = {26'h0, q.win1};
			`THC_OFS_SYNC2: rd_val = {26'h0, q.win2};
			`THC_OFS_STATUS: rd_val = {25'h0, q.seen, q.comb_rel, pair_two_fault_o, pair_one_fault_o, q.pair_rel};
			default: begin
				rd_val = 32'h0000_0000;
				addr_ok = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		d.s1 = {cycle_req_i, enable_i, two_hand_i, p2_b_i, p2_a_i, p1_b_i, p1_a_i};
		d.s2 = q.s1;
		d.tick = 1'b0;
		if (q.div >= 16'(CYCLE_CLKS - 1)) begin
			d.div = 16'h0000;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 16'h0001;
		end
		// setup phase latches the answer so the access phase needs no wait
		if (psel_i && !penable_i) begin
			d.rdata = rd_val;
			d.err = !addr_ok;
			if (pwrite_i && (paddr_i == `THC_OFS_SYNC1 || paddr_i == `THC_OFS_SYNC2)
				&& pwdata_i[5:0] > `THC_SYNC_MAX_STEPS) begin
				d.err = 1'b1;
			end
		end
		if (psel_i && penable_i && pwrite_i && !q.err) begin
			case (paddr_i)
				`THC_OFS_CTRL: begin
					d.run = pwdata_i[`THC_CTRL_RUN];
					d.fall = pwdata_i[`THC_CTRL_FALL];
					d.three = pwdata_i[`THC_CTRL_THREE];
					d.n_en = pwdata_i[`THC_CTRL_NEN +: 2];
				end
				`THC_OFS_SYNC1: d.win1 = pwdata_i[5:0];
				`THC_OFS_SYNC2: d.win2 = pwdata_i[5:0];
				default: d.run = q.run;
			endcase
		end
		if (q.tick) begin
			d.cyc_prev = q.s2[9];
			d.run_prev = q.run;
			// paired-input synchronisation
			case (q.st)
				thc_pkg::ST_IDLE: begin
					if (pair_one_fault_o || pair_two_fault_o) begin
						d.st = thc_pkg::ST_LOCK;
					end else if (p1_act && p2_act) begin
						d.st = thc_pkg::ST_REL;
					end else if (p1_act || p2_act) begin
						d.st = thc_pkg::ST_WAIT;
						d.wcnt = 10'h000;
					end
				end
				thc_pkg::ST_WAIT: begin
					if (pair_one_fault_o || pair_two_fault_o) begin
						d.st = thc_pkg::ST_LOCK;
					end else if (p1_act && p2_act) begin
						d.st = thc_pkg::ST_REL;
					end else if (!p1_act && !p2_act) begin
						d.st = (p1_rest && p2_rest) ? thc_pkg::ST_IDLE : thc_pkg::ST_LOCK;
					end else if (q.wcnt >= INTER_TICKS - 10'h001) begin
						d.st = thc_pkg::ST_LOCK;
					end else begin
						d.wcnt = q.wcnt + 10'h001;
					end
				end
				thc_pkg::ST_REL: begin
					if (!(p1_act && p2_act)) begin
						d.st = thc_pkg::ST_LOCK;
					end
				end
				thc_pkg::ST_LOCK: begin
					if (p1_rest && p2_rest && !pair_one_fault_o && !pair_two_fault_o) begin
						d.st = thc_pkg::ST_IDLE;
					end
				end
				default: d.st = thc_pkg::ST_LOCK;
			endcase
			d.pair_rel = (d.st == thc_pkg::ST_REL);
			// multi-operator combiner
			if (cyc_edge || restart) begin
				d.seen = 3'h0;
				d.comb_rel = 1'b0;
			end else begin
				d.seen = q.seen | (~q.s2[6:4] & th_m);
				d.comb_rel = en_ok && th_ok && ((q.seen & th_m) == th_m);
			end
		end
		if (!q.run) begin
			d.st = thc_pkg::ST_IDLE;
			d.wcnt = 10'h000;
			d.pair_rel = 1'b0;
			d.seen = 3'h0;
			d.comb_rel = 1'b0;
			d.run_prev = 1'b0;
			d.cyc_prev = q.s2[9];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= thc_pkg::ST_IDLE;
		end else begin
			q <= d;
		end
	end

	assign prdata_o = q.rdata;
	assign pslverr_o = q.err;
	assign pready_o = 1'b1;
	assign pair_release_o = q.pair_rel;
	assign multi_release_o = q.comb_rel;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	AST_STOP_CLEARS: assert property (!q.run |=> !pair_release_o && !multi_release_o && q.seen == 3'h0)
		else $error("outputs not cleared while stopped");
	AST_PAIR_BOTH: assert property ($rose(pair_release_o) |-> $past(p1_act && p2_act))
		else $error("pair release without both pairs actuated");
	AST_WIN_BOUND: assert property (q.st == thc_pkg::ST_WAIT |-> q.wcnt < INTER_TICKS)
		else $error("inter-pair counter past window");
	AST_LATE_LOCK: assert property (q.tick && q.run && q.st == thc_pkg::ST_WAIT && q.wcnt == INTER_TICKS - 10'h001
		&& !(p1_act && p2_act) |=> q.st != thc_pkg::ST_REL && !pair_release_o)
		else $error("release after window expired");
	AST_IDLE_REST: assert property ((q.run && q.st == thc_pkg::ST_LOCK) ##1 (q.st == thc_pkg::ST_IDLE)
		|-> $past(p1_rest && p2_rest))
		else $error("idle entered without both pairs at rest");
	AST_EN_LOW: assert property (q.tick && !en_ok |=> !multi_release_o)
		else $error("combined release with an enable low");
	AST_TH_LOW: assert property (q.tick && !th_ok |=> !multi_release_o)
		else $error("combined release with a hand input low");
	AST_EDGE: assert property (q.tick && cyc_edge |=> !multi_release_o && q.seen == 3'h0)
		else $error("cycle request edge did not drop release");
	AST_SEEN: assert property ($rose(multi_release_o) |-> $past(((q.seen & th_m) == th_m) && en_ok && th_ok))
		else $error("combined release without low phase on each hand");

	// faults come only from a pair's own synchronous time, never from the window
	AST_FAULT_BLOCK: assert property (q.tick && (pair_one_fault_o || pair_two_fault_o) |=> !pair_release_o)
		else $error("pair release while a pair fault stands");
	AST_NO_WIN_ONE: assert property (q.win1 == 6'h00 && !pair_one_fault_o |=> !pair_one_fault_o)
		else $error("pair one fault with its synchronous time off");
	AST_NO_WIN_TWO: assert property (q.win2 == 6'h00 && !pair_two_fault_o |=> !pair_two_fault_o)
		else $error("pair two fault with its synchronous time off");
	AST_WIN_LIMIT: assert property (q.win1 <= `THC_SYNC_MAX_STEPS && q.win2 <= `THC_SYNC_MAX_STEPS)
		else $error("synchronous time above its limit");
	AST_STOP_FAULTS: assert property (!q.run |=> !pair_one_fault_o && !pair_two_fault_o)
		else $error("fault flag held while stopped");
	AST_WAIT_START: assert property (q.st != thc_pkg::ST_WAIT ##1 q.st == thc_pkg::ST_WAIT |-> q.wcnt == 10'h000)
		else $error("window count not restarted");
	AST_LOCK_HOLD: assert property (q.run && q.st == thc_pkg::ST_LOCK && !(p1_rest && p2_rest)
		|=> q.st == thc_pkg::ST_LOCK)
		else $error("lock left without both pairs at rest");
	AST_REL_DROP: assert property (q.tick && q.st == thc_pkg::ST_REL && !(p1_act && p2_act) |=> !pair_release_o)
		else $error("pair release held after a pair let go");

	// while running, outputs may only move on a logic cycle, so a short pin glitch cannot pulse them
	AST_OUT_STABLE: assert property (!$past(q.tick) && $past(q.run) |-> $stable(pair_release_o)
		&& $stable(multi_release_o) && $stable(pair_one_fault_o) && $stable(pair_two_fault_o))
		else $error("outputs changed between logic cycles");
	AST_RESTART_CLR: assert property (q.tick && restart |=> !multi_release_o && q.seen == 3'h0)
		else $error("start did not demand a fresh release");
	AST_SEEN_KEEP: assert property (q.run && q.tick && !cyc_edge && !restart |=> (q.seen & $past(q.seen)) == $past(q.seen))
		else $error("low-seen bit lost without a restart");
	AST_REL_READY: assert property (q.run && q.tick && !cyc_edge && !restart && en_ok && th_ok
		&& ((q.seen & th_m) == th_m) |=> multi_release_o)
		else $error("combined release missing with all conditions met");

	CVR_PAIR_REL: cover property ($rose(pair_release_o));
	CVR_MULTI_REL: cover property ($rose(multi_release_o));
	CVR_LATE: cover property (q.st == thc_pkg::ST_WAIT ##1 q.st == thc_pkg::ST_LOCK);
	CVR_EDGE_DROP: cover property (multi_release_o && q.tick && cyc_edge);
	CVR_FAULT: cover property ($rose(pair_one_fault_o) || $rose(pair_two_fault_o));
endmodule : two_hand_control_monitor

/* File: tb/ops_model.sv */
`timescale 1ns/1ps
module ops_model (
	// commands from the bench
	input wire logic [1:0] m1_i,
	input wire logic [1:0] m2_i,
	input wire logic [2:0] hand_i,
	input wire logic [1:0] en_i,
	input wire logic cyc_i,
	// pins towards the block
	output logic p1_a_o,
	output logic p1_b_o,
	output logic p2_a_o,
	output logic p2_b_o,
	output logic [2:0] hand_o,
	output logic [1:0] en_o,
	output logic cyc_o
);
	// mode 0 rest, 1 pressed, 2 one channel stuck so both read high
	assign p1_a_o = m1_i != 2'h0;
	assign p1_b_o = m1_i != 2'h1;
	assign p2_a_o = m2_i != 2'h0;
	assign p2_b_o = m2_i != 2'h1;
	// hand and enable levels come already evaluated upstream
	assign hand_o = hand_i;
	assign en_o = en_i;
	// cycle request is plain sequencing, never a safety path
	assign cyc_o = cyc_i;
endmodule : ops_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0, rdat, rd;
	logic rdy, serr, er, p1a, p1b, p2a, p2b, cr, prel, f1, f2, mrel;
	logic [1:0] m1 = 2'h0, m2 = 2'h0, ec = 2'h0, en;
	logic [2:0] hc = 3'h0, th;
	logic cyc = 1'b0;
	int bad_count = 0, checks_done = 0, d, k;
	integer seed = 32'h9671;
	always #10 core_clk_i = ~core_clk_i;
	ops_model ops_model_i (.m1_i(m1), .m2_i(m2), .hand_i(hc), .en_i(ec), .cyc_i(cyc), .p1_a_o(p1a),
		.p1_b_o(p1b), .p2_a_o(p2a), .p2_b_o(p2b), .hand_o(th), .en_o(en), .cyc_o(cr));
	// short logic cycle keeps the 500 tick window affordable
	two_hand_control_monitor #(.CYCLE_CLKS(4)) two_hand_control_monitor_i (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
		.prdata_o(rdat), .pready_o(rdy), .pslverr_o(serr), .p1_a_i(p1a), .p1_b_i(p1b), .p2_a_i(p2a),
		.p2_b_i(p2b), .two_hand_i(th), .enable_i(en), .cycle_req_i(cr), .pair_release_o(prel),
		.pair_one_fault_o(f1), .pair_two_fault_o(f2), .multi_release_o(mrel));
	////////////////////////////////////////
	task end_sim;
		$display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t %s seen %h expected %h", $time, w, seen, exp);
		end
	endtask : chk
	task tk(input int n);
		repeat (n * 4) @(posedge core_clk_i);
	endtask : tk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		int n;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= dat;
		@(posedge core_clk_i);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		rd = rdat;
		er = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			end_sim();
		end
		@(posedge core_clk_i);
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read data");
		chk(er, e, "slave error");
	endtask : rchk
	task pc(input logic [2:0] exp);
		chk({prel, f1, f2}, exp, "pair outputs");
	endtask : pc
	task mc(input logic exp);
		chk(mrel, exp, "combined release");
	endtask : mc
	////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge core_clk_i);
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		rchk(8'h00, 32'h0, 1'b0);
		rchk(8'h04, 32'h0, 1'b0);
		rchk(8'h10, 32'h0, 1'b1);
		apb(1'b1, 8'h04, 32'h33);
		chk(er, 1'b1, "window above limit");
		apb(1'b1, 8'h04, 32'h32);
		rchk(8'h04, 32'h32, 1'b0);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		tk(4);
		pc(3'h0);
		// random gap stays inside the fixed window
		d = 1 + $unsigned($random(seed)) % 400;
		m1 <= 2'h1;
		tk(d);
		m2 <= 2'h1;
		tk(4);
		pc(3'h4);
		// low-seen bits of both used hand inputs are already set, as the hands rest low
		rchk(8'h0c, 32'h31, 1'b0);
		m1 <= 2'h0;
		tk(4);
		pc(3'h0);
		m2 <= 2'h0;
		tk(4);
		// second pair first, then far outside the window
		m2 <= 2'h1;
		tk(520);
		m1 <= 2'h1;
		tk(4);
		pc(3'h0);
		m1 <= 2'h0;
		m2 <= 2'h0;
		tk(4);
		for (k = 0; k < 2; k++) begin
			apb(1'b1, k ? 8'h08 : 8'h04, 32'h1);
			if (k) m2 <= 2'h2;
			else m1 <= 2'h2;
			tk(5);
			pc(3'h0);
			tk(15);
			pc(k ? 3'h1 : 3'h2);
			m1 <= 2'h0;
			m2 <= 2'h0;
			tk(4);
			pc(3'h0);
		end
		hc <= 3'h7;
		ec <= 2'h3;
		apb(1'b1, 8'h00, 32'h0);
		tk(4);
		mc(1'b0);
		apb(1'b1, 8'h00, 32'h15);
		tk(4);
		mc(1'b0);
		d = $unsigned($random(seed)) % 3;
		for (k = 0; k < 3; k++) begin
			hc[(d + k) % 3] <= 1'b0;
			tk(2);
			mc(1'b0);
			hc[(d + k) % 3] <= 1'b1;
			tk(4);
			mc(k == 2);
		end
		d = $unsigned($random(seed)) % 2;
		ec[d] <= 1'b0;
		tk(4);
		mc(1'b0);
		ec[d] <= 1'b1;
		tk(4);
		mc(1'b1);
		cyc <= 1'b1;
		tk(2);
		mc(1'b0);
		tk(20);
		mc(1'b0);
		hc <= 3'h0;
		tk(2);
		hc <= 3'h7;
		tk(4);
		mc(1'b1);
		apb(1'b1, 8'h00, 32'h17);
		cyc <= 1'b0;
		tk(2);
		mc(1'b0);
		hc <= 3'h0;
		tk(2);
		hc <= 3'h7;
		tk(4);
		mc(1'b1);
		// two operators, no enables: third hand and enables ignored
		apb(1'b1, 8'h00, 32'h1);
		ec <= 2'h0;
		hc <= 3'h3;
		cyc <= 1'b1;
		tk(4);
		mc(1'b0);
		hc <= 3'h0;
		tk(2);
		hc <= 3'h3;
		tk(4);
		mc(1'b1);
		apb(1'b1, 8'h00, 32'h0);
		tk(1);
		mc(1'b0);
		end_sim();
	end
endmodule : tb_top
